// *** include/qr_pkg.sv ***
// Constants and carrier types for the flyback switching controller.
// Assumes a 100 MHz core clock; long intervals are counted in 1 us ticks.
package qr_pkg;
    // -----------------------------------------------------------
    // Timing
    // -----------------------------------------------------------
    localparam int CLK_MHZ    = 100;
    localparam int LEB_NS     = 250;
    localparam int LEB_CYC    = (LEB_NS * CLK_MHZ + 999) / 1000;
    localparam int MASK_NS    = 500;
    localparam int MASK_CYC   = (MASK_NS * CLK_MHZ + 999) / 1000;
    localparam int TOUT2_NS   = 24000;
    localparam int TOUT2_CYC  = (TOUT2_NS * CLK_MHZ) / 1000;
    localparam int TICK_CYC   = CLK_MHZ;
    localparam int TOUT1_US   = 70;
    localparam int LATCH_US   = 100;
    localparam int SS_END_US  = 4000;
    localparam int OLP_MS     = 128;
    localparam int OLP_US     = OLP_MS * 1000;
    localparam int RESTART_MS = 2048;
    localparam int RESTART_US = RESTART_MS * 1000;
    localparam logic [1:0] OVP_PULSES = 2'h3;
    // -----------------------------------------------------------
    // Current limit step codes
    // -----------------------------------------------------------
    localparam logic [2:0] LIM_12P5 = 3'h0;
    localparam logic [2:0] LIM_25   = 3'h1;
    localparam logic [2:0] LIM_50   = 3'h2;
    localparam logic [2:0] LIM_75   = 3'h3;
    localparam logic [2:0] LIM_FULL = 3'h4;
    // -----------------------------------------------------------
    // Register map
    // -----------------------------------------------------------
    localparam logic [11:0] CTRL_OFS    = 12'h000;
    localparam logic [11:0] STATUS_OFS  = 12'h004;
    localparam logic [11:0] IRQ_STA_OFS = 12'h008;
    localparam logic [11:0] IRQ_CLR_OFS = 12'h00C;
    localparam logic [11:0] IRQ_EN_OFS  = 12'h010;
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_PULSE_BIT = 1;
    localparam logic CTRL_RUN_RST   = 1'b1;
    localparam logic CTRL_PULSE_RST = 1'b0;
    localparam int ST_POS  = 0;
    localparam int LIM_POS = 4;
    localparam int OLA_POS = 8;
    localparam int OVC_POS = 12;
    localparam int EV_W       = 4;
    localparam int EV_LATCH   = 0;
    localparam int EV_OLP     = 1;
    localparam int EV_CSOPEN  = 2;
    localparam int EV_RESTART = 3;
    // -----------------------------------------------------------
    // Types
    // -----------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_OFFT  = 3'h1,
        ST_ON    = 3'h3,
        ST_OLP   = 3'h2,
        ST_LATCH = 3'h6
    } fsm_e;
    typedef struct packed {
        logic oc;         // Current sense at limit
        logic valley;     // Winding at or below valley threshold
        logic ring;       // Winding above ring present threshold
        logic zt_ovp;     // Winding overvoltage detect
        logic cs_open;    // Current sense pin open
        logic fb_ovl;     // Feedback above overload set threshold
        logic fb_rel;     // Feedback below overload clear threshold
        logic freq_ok;    // Maximum frequency limit allows a pulse
        logic supply_low; // Supply below low reset threshold
        logic latch_rel;  // Supply below latch release threshold
    } cmp_s;
endpackage

// *** verilog/qr_flyback_ctrl.sv ***
// Flyback gate sequencing and protection with an APB register slave.
// Comparator flags arrive synchronous to ref_clk; APB runs on ref_clk.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Ignore over-current for the blanking time after each gate rise.
// - With gate off, turn on when winding reaches the valley level.
// - Mask valley and overvoltage comparators for a time after gate fall.
// - Force turn-on if winding shows no ringing for the first timeout.
// - Force turn-on if no further valley follows within the second timeout.
// - Arm the second timeout only after a valley in this period.
// - Skip a valley while the frequency limit forbids a pulse.
// - Supply low resets control; soft start runs on resumption.
// - Step current limit 12.5, 25, 50, 75 percent, then full.
// - Continuous overvoltage for the latch time within one switching period latches switching off.
// - Pulse mode: three overvoltage pulses start the latch timer.
// - Overvoltage detection runs only in ST_ON and ST_OFFT, after the mask.
// - Current sense open stops switching; it resumes when cleared.
// - Overload held for its period forces both gate outputs low.
// - Feedback below clear threshold resets the overload timer.
// - After overload stop, wait the restart delay, then soft start.
// - Persistent overload stops again one overload period after restart.
// - A latched stop clears only when supply falls below release level.
module qr_flyback_ctrl #(
    parameter int TICK_CYC   = qr_pkg::TICK_CYC,
    parameter int TOUT1_US   = qr_pkg::TOUT1_US,
    parameter int LATCH_US   = qr_pkg::LATCH_US,
    parameter int SS_END_US  = qr_pkg::SS_END_US,
    parameter int OLP_US     = qr_pkg::OLP_US,
    parameter int RESTART_US = qr_pkg::RESTART_US
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire qr_pkg::cmp_s comparator_flags,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    output logic              flyback_gate_drive,
    output logic              pfc_run_enable,
    output logic [2:0]        cs_limit_step,
    output logic              irq
);
    // -----------------------------------------------------------
    // Parameter check
    // -----------------------------------------------------------
    if (TICK_CYC < 2 || TICK_CYC > 128 || SS_END_US < 8 || TOUT1_US < 1 ||
        LATCH_US < 1 || OLP_US < 1 || RESTART_US < 1) begin : g_bad_param
        $error("qr_flyback_ctrl: unsupported parameter value");
    end

    typedef struct packed {
        qr_pkg::cmp_s          sync1;
        qr_pkg::cmp_s          sync2;
        qr_pkg::fsm_e          st;
        logic                  gate;
        logic                  pfc;
        logic [2:0]            lim;
        logic [6:0]            leb;
        logic [6:0]            mask;
        logic [11:0]           t2;
        logic                  t2_arm;
        logic                  valley_prev;
        logic [31:0]           t1;
        logic [6:0]            div;
        logic [31:0]           ss;
        logic [1:0]            ovp_cnt;
        logic [31:0]           ovp_tmr;
        logic                  ovp_seen;
        logic                  ovp_prev;
        logic                  olp_arm;
        logic [31:0]           olp;
        logic                  run;
        logic                  pulse_mode;
        logic [qr_pkg::EV_W-1:0] ist;
        logic [qr_pkg::EV_W-1:0] ien;
        logic                  irq;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
    } state_s;

    state_s       s_q;
    state_s       s_d;
    logic [1:0]   rst_sync_q;
    logic         rst_sync_n;
    qr_pkg::cmp_s c;
    logic         tick;
    logic         running;
    logic         masked;
    logic         v_edge;
    logic         t1_exp;
    logic         t2_exp;
    logic         ovp_v;
    logic         ovp_latch;
    logic         olp_hit;
    logic         stop_req;
    logic         acc;
    logic [qr_pkg::EV_W-1:0] ev;

    // Current limit step from elapsed soft-start time
    function automatic logic [2:0] lim_of(input logic [31:0] t);
        if (t < 32'(SS_END_US / 8))
            return qr_pkg::LIM_12P5;
        else if (t < 32'(SS_END_US / 4))
            return qr_pkg::LIM_25;
        else if (t < 32'(SS_END_US / 2))
            return qr_pkg::LIM_50;
        else if (t < 32'(SS_END_US))
            return qr_pkg::LIM_75;
        else
            return qr_pkg::LIM_FULL;
    endfunction

    // -----------------------------------------------------------
    // Reset release
    // -----------------------------------------------------------
    // Two-stage release of the asynchronous reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_sync_n = rst_sync_q[1];

    // -----------------------------------------------------------
    // Next state
    // -----------------------------------------------------------
    // Decode helpers shared by the state update and the checks
    assign c       = s_q.sync2;
    assign tick    = (s_q.div == 7'(TICK_CYC - 1));
    assign running = (s_q.st == qr_pkg::ST_ON) || (s_q.st == qr_pkg::ST_OFFT);
    assign masked  = (s_q.st == qr_pkg::ST_OFFT) && (s_q.mask != 7'h00);
    assign v_edge  = (s_q.st == qr_pkg::ST_OFFT) && !masked && c.valley && !s_q.valley_prev;
    assign t1_exp  = (s_q.t1 >= 32'(TOUT1_US));
    assign t2_exp  = s_q.t2_arm && (s_q.t2 == 12'h000);
    assign ovp_v   = running && !masked && c.zt_ovp;
    assign ovp_latch = running && (s_q.ovp_tmr >= 32'(LATCH_US));
    assign olp_hit = running && (s_q.olp >= 32'(OLP_US));
    assign stop_req = c.supply_low || !s_q.run || c.cs_open || ovp_latch || olp_hit;
    assign acc     = psel && penable && s_q.pready;

    // Whole next-state function
    always_comb begin
        s_d       = s_q;
        ev        = '0;
        s_d.sync1 = comparator_flags;
        s_d.sync2 = s_q.sync1;
        s_d.div   = tick ? 7'h00 : s_q.div + 7'h01;
        s_d.valley_prev = c.valley;
        s_d.ovp_prev    = ovp_v;
        case (s_q.st)
            qr_pkg::ST_IDLE: begin
                s_d.gate = 1'b0;
                if (s_q.run && !c.supply_low && !c.cs_open) begin
                    s_d.st      = qr_pkg::ST_OFFT;
                    s_d.ss      = '0;
                    s_d.t1      = '0;
                    s_d.t2_arm  = 1'b0;
                    s_d.mask    = 7'h00;
                    s_d.ovp_cnt = 2'h0;
                    s_d.ovp_tmr = '0;
                    s_d.olp     = '0;
                    s_d.olp_arm = 1'b0;
                end
            end
            qr_pkg::ST_ON: begin
                if (s_q.leb != 7'h00)
                    s_d.leb = s_q.leb - 7'h01;
                else if (c.oc) begin
                    s_d.gate   = 1'b0;
                    s_d.st     = qr_pkg::ST_OFFT;
                    s_d.mask   = 7'(qr_pkg::MASK_CYC);
                    s_d.t1     = '0;
                    s_d.t2_arm = 1'b0;
                    // New period: drop the pulse count if last period had none
                    if (!s_q.ovp_seen) begin
                        s_d.ovp_cnt = 2'h0;
                        s_d.ovp_tmr = '0;
                    end
                    s_d.ovp_seen = 1'b0;
                end
            end
            qr_pkg::ST_OFFT: begin
                if (masked)
                    s_d.mask = s_q.mask - 7'h01;
                if (c.ring && !masked)
                    s_d.t1 = '0;
                else if (tick)
                    s_d.t1 = s_q.t1 + 32'h1;
                if (s_q.t2_arm && s_q.t2 != 12'h000)
                    s_d.t2 = s_q.t2 - 12'h001;
                if ((c.valley && !masked && c.freq_ok) || t1_exp || t2_exp) begin
                    s_d.gate   = 1'b1;
                    s_d.st     = qr_pkg::ST_ON;
                    s_d.leb    = 7'(qr_pkg::LEB_CYC);
                    s_d.t2_arm = 1'b0;
                end else if (v_edge) begin
                    s_d.t2_arm = 1'b1;
                    s_d.t2     = 12'(qr_pkg::TOUT2_CYC);
                end
            end
            qr_pkg::ST_OLP: begin
                s_d.gate = 1'b0;
                if (tick)
                    s_d.olp = s_q.olp + 32'h1;
                if (s_q.olp >= 32'(RESTART_US)) begin
                    s_d.st   = qr_pkg::ST_OFFT;
                    s_d.ss   = '0;
                    s_d.olp  = '0;
                    s_d.t1   = '0;
                    s_d.mask = 7'h00;
                    ev[qr_pkg::EV_RESTART] = 1'b1;
                end
            end
            qr_pkg::ST_LATCH: begin
                s_d.gate = 1'b0;
                if (c.latch_rel)
                    s_d.st = qr_pkg::ST_IDLE;
            end
            default: begin
                s_d.st   = qr_pkg::ST_IDLE;
                s_d.gate = 1'b0;
            end
        endcase

        // Soft start, overload and overvoltage timing while switching
        if (running) begin
            if (tick && s_q.ss < 32'(SS_END_US))
                s_d.ss = s_q.ss + 32'h1;
            if (c.fb_rel) begin
                s_d.olp_arm = 1'b0;
                s_d.olp     = '0;
            end else if (c.fb_ovl)
                s_d.olp_arm = 1'b1;
            if (s_q.olp_arm && !c.fb_rel && tick)
                s_d.olp = s_q.olp + 32'h1;
            if (s_q.pulse_mode) begin
                if (ovp_v && !s_q.ovp_prev) begin
                    s_d.ovp_seen = 1'b1;
                    if (s_q.ovp_cnt != qr_pkg::OVP_PULSES)
                        s_d.ovp_cnt = s_q.ovp_cnt + 2'h1;
                end
                if (s_q.ovp_cnt == qr_pkg::OVP_PULSES && tick)
                    s_d.ovp_tmr = s_q.ovp_tmr + 32'h1;
            end else if (ovp_v) begin
                if (tick)
                    s_d.ovp_tmr = s_q.ovp_tmr + 32'h1;
            end else if (!masked)
                s_d.ovp_tmr = '0;
        end

        // Stop priorities; a latched stop ignores supply low
        if (s_q.st != qr_pkg::ST_LATCH && c.supply_low) begin
            s_d.st   = qr_pkg::ST_IDLE;
            s_d.gate = 1'b0;
        end else if (running && stop_req) begin
            s_d.gate = 1'b0;
            if (ovp_latch) begin
                s_d.st = qr_pkg::ST_LATCH;
                ev[qr_pkg::EV_LATCH] = 1'b1;
            end else if (olp_hit) begin
                s_d.st  = qr_pkg::ST_OLP;
                s_d.olp = '0;
                ev[qr_pkg::EV_OLP] = 1'b1;
            end else begin
                s_d.st = qr_pkg::ST_IDLE;
                ev[qr_pkg::EV_CSOPEN] = c.cs_open;
            end
        end
        s_d.lim = lim_of(s_d.ss);
        s_d.pfc = (s_d.st == qr_pkg::ST_ON || s_d.st == qr_pkg::ST_OFFT) &&
                  (s_d.ss >= 32'(SS_END_US));

        // APB: one wait state, writes land on the completing edge
        s_d.pready  = psel && penable && !s_q.pready;
        s_d.pslverr = 1'b0;
        s_d.prdata  = '0;
        if (psel && penable && !s_q.pready) begin
            if (paddr == qr_pkg::CTRL_OFS) begin
                s_d.prdata[qr_pkg::CTRL_RUN_BIT]   = s_q.run;
                s_d.prdata[qr_pkg::CTRL_PULSE_BIT] = s_q.pulse_mode;
            end else if (paddr == qr_pkg::STATUS_OFS) begin
                s_d.prdata[qr_pkg::ST_POS +: 3]  = s_q.st;
                s_d.prdata[qr_pkg::LIM_POS +: 3] = s_q.lim;
                s_d.prdata[qr_pkg::OLA_POS]      = s_q.olp_arm;
                s_d.prdata[qr_pkg::OVC_POS +: 2] = s_q.ovp_cnt;
            end else if (paddr == qr_pkg::IRQ_STA_OFS)
                s_d.prdata[qr_pkg::EV_W-1:0] = s_q.ist;
            else if (paddr == qr_pkg::IRQ_CLR_OFS)
                s_d.prdata = '0;
            else if (paddr == qr_pkg::IRQ_EN_OFS)
                s_d.prdata[qr_pkg::EV_W-1:0] = s_q.ien;
            else
                s_d.pslverr = 1'b1;
        end
        if (acc && pwrite) begin
            if (paddr == qr_pkg::CTRL_OFS) begin
                s_d.run        = pwdata[qr_pkg::CTRL_RUN_BIT];
                s_d.pulse_mode = pwdata[qr_pkg::CTRL_PULSE_BIT];
            end else if (paddr == qr_pkg::IRQ_CLR_OFS)
                s_d.ist = s_q.ist & ~pwdata[qr_pkg::EV_W-1:0];
            else if (paddr == qr_pkg::IRQ_EN_OFS)
                s_d.ien = pwdata[qr_pkg::EV_W-1:0];
        end
        // Events set after the clear so a same-cycle event survives
        s_d.ist = s_d.ist | ev;
        s_d.irq = |(s_d.ist & s_d.ien);
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_q            <= '0;
            s_q.run        <= qr_pkg::CTRL_RUN_RST;
            s_q.pulse_mode <= qr_pkg::CTRL_PULSE_RST;
            // Supply counts as low until the first synced sample arrives
            s_q.sync1.supply_low <= 1'b1;
            s_q.sync2.supply_low <= 1'b1;
        end else
            s_q <= s_d;
    end

    // Outputs straight from the state register
    assign flyback_gate_drive = s_q.gate;
    assign pfc_run_enable     = s_q.pfc;
    assign cs_limit_step      = s_q.lim;
    assign irq                = s_q.irq;
    assign prdata             = s_q.prdata;
    assign pready             = s_q.pready;
    assign pslverr            = s_q.pslverr;

    // -----------------------------------------------------------
    // Checks
    // -----------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_n);

    sequence s_gate_off;
        $fell(s_q.gate) && s_q.st == qr_pkg::ST_OFFT;
    endsequence

    chk_blank_time: assert property (
        s_gate_off |-> $past(s_q.leb) == 7'h00 && $past(s_q.leb, 2) <= 7'h01)
        else $error("gate ended inside blanking");
    chk_valley_on: assert property (
        s_q.st == qr_pkg::ST_OFFT && !masked && c.valley && c.freq_ok && !stop_req
        |=> s_q.gate)
        else $error("valley did not start a pulse");
    chk_mask_off: assert property (
        s_gate_off |=> (!s_q.gate && !s_q.ovp_prev)[*8])
        else $error("comparators acted inside mask");
    chk_ring_tout: assert property (
        s_q.st == qr_pkg::ST_OFFT && t1_exp && !stop_req |=> s_q.gate)
        else $error("first timeout did not force on");
    chk_valley_tout: assert property (
        s_q.st == qr_pkg::ST_OFFT && t2_exp && !stop_req |=> s_q.gate)
        else $error("second timeout did not force on");
    chk_arm_cause: assert property (
        $rose(s_q.t2_arm) |-> $past(v_edge))
        else $error("second timeout armed without valley");
    chk_freq_hold: assert property (
        s_q.st == qr_pkg::ST_OFFT && !c.freq_ok && !t1_exp && !t2_exp |=> !s_q.gate)
        else $error("pulse started against frequency limit");
    chk_supply_reset: assert property (
        c.supply_low && s_q.st != qr_pkg::ST_LATCH |=> s_q.st == qr_pkg::ST_IDLE && !s_q.gate)
        else $error("supply low did not reset");
    chk_ovp_latch: assert property (
        ovp_latch |=> s_q.st == qr_pkg::ST_LATCH ##1 !s_q.gate)
        else $error("overvoltage did not latch");
    chk_cs_open: assert property (
        c.cs_open |=> !s_q.gate)
        else $error("switching with sense pin open");
    chk_olp_stop: assert property (
        olp_hit && !c.supply_low && !ovp_latch |=> s_q.st == qr_pkg::ST_OLP && !s_q.gate && !s_q.pfc)
        else $error("overload did not stop both gates");
    chk_olp_clear: assert property (
        running && c.fb_rel |=> s_q.olp == 32'h0 && !s_q.olp_arm)
        else $error("overload timer not cleared");
    chk_latch_hold: assert property (
        s_q.st == qr_pkg::ST_LATCH && !c.latch_rel |=> s_q.st == qr_pkg::ST_LATCH)
        else $error("latch left without release");
endmodule // qr_flyback_ctrl
`default_nettype wire

// *** verif/qr_power_stage.sv ***
// Behavioural power stage: MOSFET current ramp and ringing winding.
// Assumes the gate input is the controller's registered gate output.
`timescale 1ns/10ps
`default_nettype none
module qr_power_stage (
    input  wire logic ref_clk,
    input  wire logic gate,
    output logic      oc,
    output logic      valley,
    output logic      ring
);
    logic [7:0] cnt_q  = 8'h00;
    logic       gate_q = 1'b0;
    // Cycles since the last gate edge; a change into or out of unknown counts as an edge
    always @(posedge ref_clk) begin
        gate_q <= gate;
        cnt_q  <= (gate !== gate_q) ? 8'h00 : cnt_q + 8'h01;
    end
    // Current hits its limit at once; the winding rings early, inside the mask
    assign oc     = gate && (cnt_q >= 8'h02);
    assign ring   = !gate && cnt_q[3];
    assign valley = !gate && (cnt_q >= 8'h03) && !cnt_q[3];
endmodule // qr_power_stage
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the flyback controller with APB master.
// Assumes shortened tick and interval parameters set below.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rnd;
    logic pready, pslverr, gate, pfc, irq, oc, valley, ring;
    logic ovl = 0, ovp = 0, csop = 0, rel = 0, fok = 1, slow = 1;
    logic [1:0] hush = 0; // Bit 0 hides valleys, bit 1 hides ringing
    logic [2:0] step;
    logic [32:0] exp_q[$], msk_q[$];
    int err_total = 0, checks_done = 0, cyc = 0, n, seed = 32'hCE47;
    qr_pkg::cmp_s flags;
    assign flags = '{oc: oc, valley: valley && !hush[0], ring: ring && !hush[1], zt_ovp: ovp, cs_open: csop,
                     fb_ovl: ovl, fb_rel: !ovl, freq_ok: fok, supply_low: slow, latch_rel: rel};
    qr_flyback_ctrl #(.TICK_CYC(4), .LATCH_US(3), .SS_END_US(16), .OLP_US(20),
        .RESTART_US(30)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .comparator_flags(flags),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .flyback_gate_drive(gate),
        .pfc_run_enable(pfc), .cs_limit_step(step), .irq(irq));
    qr_power_stage u_stage (.ref_clk(ref_clk), .gate(gate), .oc(oc), .valley(valley), .ring(ring));
    always #5 ref_clk = ~ref_clk;
    // ---------------------------------------------------------
    // Checking and closing
    // ---------------------------------------------------------
    task automatic chk(input logic [32:0] g, input logic [32:0] e, input logic [32:0] m);
        checks_done++;
        if ((g & m) !== (e & m)) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g & m, e & m);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Read results are matched against the oldest note
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, exp_q.pop_front(), msk_q.pop_front());
    end
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    // ---------------------------------------------------------
    // Drivers
    // ---------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e,
                       input logic [32:0] m);
        @(posedge ref_clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        if (!w) begin
            exp_q.push_back(e); msk_q.push_back(m);
        end
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        psel <= 0; penable <= 0;
    endtask
    task automatic wait_gate(input logic v, input int lim);
        n = 0;
        while (gate !== v && n < lim) begin
            @(posedge ref_clk); n++;
        end
        chk({32'h0, gate}, {32'h0, v}, 33'h1);
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1;
        repeat (4) @(posedge ref_clk);
        apb(0, qr_pkg::CTRL_OFS, 0, 33'h1, 33'h1FFFFFFFF);
        apb(0, qr_pkg::IRQ_EN_OFS, 0, 33'h0, 33'h1FFFFFFFF);
        apb(0, 12'h100, 0, {1'b1, 32'h0}, 33'h1FFFFFFFF);
        rnd = $random(seed);
        apb(1, qr_pkg::IRQ_EN_OFS, rnd, 0, 0);
        apb(0, qr_pkg::IRQ_EN_OFS, 0, {29'h0, rnd[3:0]}, 33'h1FFFFFFFF);
        apb(1, qr_pkg::IRQ_EN_OFS, 32'h2, 0, 0);
        chk({30'h0, step}, {30'h0, qr_pkg::LIM_12P5}, 33'h7);
        chk({31'h0, pfc, gate}, 33'h0, 33'h3);
        hush <= 2'h3;
        slow <= 0;
        wait_gate(1, 400);
        chk({32'h0, n > 270}, 33'h1, 33'h1);
        hush <= 2'h0;
        n = 0;
        while (gate === 1'b1 && n < 300) begin
            @(posedge ref_clk); n++;
        end
        chk({32'h0, n > qr_pkg::LEB_CYC}, 33'h1, 33'h1);
        n = 0;
        while (gate === 1'b0 && n < 300) begin
            @(posedge ref_clk); n++;
        end
        chk({32'h0, n >= qr_pkg::MASK_CYC}, 33'h1, 33'h1);
        repeat (100) @(posedge ref_clk);
        chk({30'h0, step}, {30'h0, qr_pkg::LIM_FULL}, 33'h7);
        chk({32'h0, pfc}, 33'h1, 33'h1);
        slow <= 1;
        repeat (6) @(posedge ref_clk);
        chk({31'h0, pfc, gate}, 33'h0, 33'h3);
        slow <= 0;
        repeat (5) @(posedge ref_clk);
        chk({30'h0, step}, {30'h0, qr_pkg::LIM_12P5}, 33'h7);
        fok <= 0;
        repeat (300) @(posedge ref_clk);
        chk({32'h0, gate}, 33'h0, 33'h1);
        hush <= 2'h1;
        wait_gate(1, 2600);
        chk({32'h0, n > 2300}, 33'h1, 33'h1);
        fok <= 1;
        hush <= 2'h0;
        ovl <= 1;
        repeat (100) @(posedge ref_clk);
        chk({31'h0, pfc, gate}, 33'h0, 33'h3);
        chk({32'h0, irq}, 33'h1, 33'h1);
        apb(0, qr_pkg::IRQ_STA_OFS, 0, 33'h2, 33'h1FFFFFFFF);
        apb(1, qr_pkg::IRQ_CLR_OFS, 32'h2, 0, 0);
        repeat (2) @(posedge ref_clk);
        chk({32'h0, irq}, 33'h0, 33'h1);
        wait_gate(1, 300);
        chk({32'h0, n > 80}, 33'h1, 33'h1);
        repeat (100) @(posedge ref_clk);
        apb(0, qr_pkg::STATUS_OFS, 0, {30'h0, qr_pkg::ST_OLP}, 33'h7);
        ovl <= 0;
        wait_gate(1, 400);
        csop <= 1;
        repeat (60) @(posedge ref_clk);
        chk({32'h0, gate}, 33'h0, 33'h1);
        csop <= 0;
        wait_gate(1, 400);
        ovp <= 1;
        repeat (600) @(posedge ref_clk);
        ovp <= 0;
        repeat (20) @(posedge ref_clk);
        apb(0, qr_pkg::STATUS_OFS, 0, {30'h0, qr_pkg::ST_LATCH}, 33'h3007);
        chk({32'h0, gate}, 33'h0, 33'h1);
        rel <= 1;
        repeat (5) @(posedge ref_clk);
        rel <= 0;
        wait_gate(1, 400);
        apb(1, qr_pkg::CTRL_OFS, 32'h3, 0, 0);
        ovp <= 1;
        repeat (500) @(posedge ref_clk);
        apb(0, qr_pkg::STATUS_OFS, 0, 33'h3006, 33'h3007);
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
